// File: core/adc_serial_port.sv
/*
 * serial control port and operating-mode sequencer of a delta-sigma
 * converter: command shifting, wake and sleep, duty-cycle and turbo timing,
 * ready signalling and serial timeout.
 * assumes the conversion result arrives on conv_result from the same clock,
 * configuration bits come from same-clock logic, pins are asynchronous.
 */
`timescale 1ns/1ps
`include "adc_port_defines.svh"
module adc_serial_port #(
    parameter int unsigned TIMEOUT_NORMAL = `ADC_TIMEOUT_NORMAL,
    parameter int unsigned TIMEOUT_TURBO = `ADC_TIMEOUT_TURBO,
    parameter int unsigned PERIOD_DIV = 1
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic cs_n_pin,
    input wire logic sclk_pin,
    input wire logic din_pin,
    output logic serial_out_ready_pin,
    output logic serial_out_ready_pin_oe,
    output logic conv_done_n_pin,
    input wire logic conversion_mode_select,
    input wire logic ready_on_output_select,
    input wire logic duty_cycle_select,
    input wire logic turbo_select,
    input wire logic [2:0] rate_select,
    input wire logic [15:0] conv_result,
    output logic modulator_clock,
    output logic converting,
    output logic powered_down,
    output logic analog_enable,
    output logic reference_enable,
    output logic excitation_current_source_enable,
    output logic low_side_switch_closed,
    output adc_port_pkg::power_state_t power_state
);
    import adc_port_pkg::*;

    port_state_t st_reg, st_next;
    logic [2:0] pins_s;
    logic cs_s, sclk_s, din_s;
    logic mod_tick;
    logic rise, fall, cmd_open, timeout, complete;
    logic start_cmd, sleep_cmd, wreg_done, cmd_done;
    logic [7:0] in_byte;
    logic [15:0] period, duty_len;
    logic [14:0] timeout_last;

    initial begin
        if (PERIOD_DIV < 1 || PERIOD_DIV > 256)
            $error("adc_serial_port: PERIOD_DIV must lie in 1..256");
        if (TIMEOUT_NORMAL < 2 || TIMEOUT_TURBO < 2 || TIMEOUT_TURBO > 32767)
            $error("adc_serial_port: timeout counts out of range");
    end

    // conversion period in modulator periods for each rate setting
    function automatic logic [15:0] conv_period(input logic [2:0] sel);
        logic [15:0] p;
        case (sel)
            3'h0: p = 16'h3200; // 20 sps normal, 5 sps duty, 40 sps turbo
            3'h1: p = 16'h1639;
            3'h2: p = 16'h0b1c;
            3'h3: p = 16'h05b7;
            3'h4: p = 16'h0308;
            3'h5: p = 16'h01ab;
            default: p = 16'h0100; // 1 ksps normal, 250 sps duty, 2 ksps turbo
        endcase
        return 16'(p / PERIOD_DIV);
    endfunction

    // cs, sclk, din cross in through two flops; cs idles high
    pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .pins_async({cs_n_pin, sclk_pin, din_pin}),
        .reset_value(3'h4),
        .pins_sync(pins_s)
    );

    // modulator timing base
    mod_clock_divider u_div (
        .clock(clock),
        .reset(reset),
        .clock_enable(clock_enable),
        .turbo_select(turbo_select),
        .mod_tick(mod_tick),
        .modulator_clock(modulator_clock)
    );

    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign din_s = pins_s[0];

    // edge detection and decode of the byte about to complete
    always_comb begin
        rise = sclk_s & ~st_reg.sclk_prev;
        fall = ~sclk_s & st_reg.sclk_prev;
        in_byte = {st_reg.in_shift[6:0], din_s};
        period = conv_period(rate_select);
        duty_len = 16'(`ADC_DUTY_IDLE_PERIODS * period);
        timeout_last = turbo_select ? 15'(TIMEOUT_TURBO - 1) : 15'(TIMEOUT_NORMAL - 1);
        cmd_open = (st_reg.bit_cnt != 3'h0) || (st_reg.wreg_left != 3'h0);
        timeout = mod_tick && cmd_open && (st_reg.timeout_cnt >= timeout_last);
        complete = mod_tick && (st_reg.state == CONVERTING)
            && (st_reg.conv_cnt >= period - 16'h0001);
    end

    // next-state: serial port, conversion sequencer, pins
    always_comb begin
        st_next = st_reg;
        start_cmd = 1'b0;
        sleep_cmd = 1'b0;
        wreg_done = 1'b0;
        cmd_done = 1'b0;
        st_next.sclk_prev = sclk_s;
        st_next.oe = ~cs_s;
        if (cs_s || timeout) begin
            // port reset: clock ignored, partial command dropped
            st_next.bit_cnt = 3'h0;
            st_next.wreg_left = 3'h0;
            st_next.in_shift = 8'h00;
            st_next.out_active = 1'b0;
            st_next.timeout_cnt = 15'h0000;
        end else begin
            if (fall) begin
                st_next.in_shift = in_byte;
                st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                if (st_reg.bit_cnt == 3'h7) begin
                    if (st_reg.wreg_left != 3'h0) begin
                        st_next.wreg_left = st_reg.wreg_left - 3'h1;
                        wreg_done = (st_reg.wreg_left == 3'h1);
                        cmd_done = wreg_done;
                    end else begin
                        cmd_done = (in_byte[7:4] != `ADC_CMD_WREG);
                        start_cmd = (in_byte[7:1] == `ADC_CMD_START);
                        sleep_cmd = (in_byte[7:1] == `ADC_CMD_SLEEP);
                        if (in_byte[7:4] == `ADC_CMD_WREG) begin
                            st_next.wreg_left = 3'({1'b0,
                                in_byte[`ADC_WREG_NN_MSB:`ADC_WREG_NN_LSB]}) + 3'h1;
                        end
                        if (in_byte[7:4] == `ADC_CMD_RDATA) begin
                            st_next.out_shift = st_reg.result;
                            st_next.out_active = 1'b0;
                        end
                    end
                end
            end
            if (rise) begin
                st_next.sdo = st_reg.out_shift[15];
                st_next.out_shift = {st_reg.out_shift[14:0], 1'b0};
                st_next.out_active = 1'b1;
                st_next.conv_done_n_pin_n = 1'b1;
            end
            if (cmd_done) begin
                st_next.timeout_cnt = 15'h0000;
            end else if (mod_tick) begin
                st_next.timeout_cnt = cmd_open ? st_reg.timeout_cnt + 15'h0001 : 15'h0000;
            end
        end

        // conversion sequencer, advanced once per modulator period
        if (mod_tick) begin
            case (st_reg.state)
                CONVERTING: begin
                    st_next.conv_cnt = st_reg.conv_cnt + 16'h0001;
                    if (st_reg.continuous && !st_reg.conv_done_n_pin_n
                            && st_reg.conv_cnt == period - 16'(`ADC_CONV_DONE_N_PIN_PULSE + 1)) begin
                        st_next.conv_done_n_pin_n = 1'b1;
                    end
                end
                DUTY_WAIT: begin
                    st_next.conv_cnt = st_reg.conv_cnt + 16'h0001;
                    if (st_reg.conv_cnt >= duty_len - 16'h0001) begin
                        st_next.state = CONVERTING;
                        st_next.conv_cnt = 16'h0000;
                    end
                end
                default: begin
                    st_next.conv_cnt = 16'h0000;
                end
            endcase
        end
        if (complete) begin
            st_next.result = conv_result;
            st_next.out_shift = conv_result;
            st_next.out_active = 1'b0;
            st_next.conv_done_n_pin_n = 1'b0;
            st_next.conv_cnt = 16'h0000;
            if (st_reg.sleep_pending) begin
                st_next.state = POWERED_DOWN;
                st_next.sleep_pending = 1'b0;
            end else if (!st_reg.continuous) begin
                st_next.state = LOW_POWER_IDLE;
            end else if (duty_cycle_select) begin
                st_next.state = DUTY_WAIT;
            end else begin
                st_next.state = CONVERTING;
            end
        end

        // commands override the sequencer
        if (start_cmd) begin
            st_next.state = CONVERTING;
            st_next.conv_cnt = 16'h0000;
            st_next.continuous = conversion_mode_select;
            st_next.sleep_pending = 1'b0;
        end else if (wreg_done) begin
            st_next.continuous = (st_reg.state == POWERED_DOWN) ? 1'b0
                : conversion_mode_select;
            st_next.state = CONVERTING;
            st_next.conv_cnt = 16'h0000;
            st_next.sleep_pending = 1'b0;
        end else if (sleep_cmd) begin
            if (st_next.state == CONVERTING) begin
                st_next.sleep_pending = 1'b1;
            end else begin
                st_next.state = POWERED_DOWN;
            end
        end

        // shared pin shows ready while no data is being shifted
        if (ready_on_output_select && !st_next.out_active) begin
            st_next.sdo = st_next.conv_done_n_pin_n;
        end
    end

    // power-up performs one single conversion
    always_ff @(posedge clock) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.state <= CONVERTING;
            st_reg.conv_done_n_pin_n <= 1'b1;
            st_reg.sclk_prev <= 1'b0;
            st_reg.result <= `ADC_RESULT_RESET;
        end else if (clock_enable) begin
            st_reg <= st_next;
        end
    end

    // pins and power controls, all from registers
    assign serial_out_ready_pin = st_reg.sdo;
    assign serial_out_ready_pin_oe = st_reg.oe;
    assign conv_done_n_pin = st_reg.conv_done_n_pin_n;
    assign power_state = st_reg.state;
    assign converting = (st_reg.state == CONVERTING);
    assign powered_down = (st_reg.state == POWERED_DOWN);
    assign analog_enable = converting;
    assign reference_enable = ~powered_down;
    assign excitation_current_source_enable = ~powered_down;
    assign low_side_switch_closed = ~powered_down;

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset || !clock_enable);

    chk_out_float: assert property (
        cs_s |=> !serial_out_ready_pin_oe && st_reg.bit_cnt == 3'h0)
        else $error("serial output driven or port active while deselected");

    chk_ready_rise: assert property (
        (rise && !cs_s && !complete && !timeout) |=> conv_done_n_pin)
        else $error("ready output did not rise on serial clock");

    chk_ready_fall: assert property (
        complete |=> !conv_done_n_pin && st_reg.result == $past(conv_result))
        else $error("ready output not low with new result");

    chk_power_off: assert property (
        powered_down |-> !analog_enable && !low_side_switch_closed
            && !excitation_current_source_enable && !reference_enable)
        else $error("analog parts powered while down");

    chk_sleep_wait: assert property (
        (converting && !start_cmd && !wreg_done && st_next.state == POWERED_DOWN)
            |-> complete)
        else $error("conversion cut short by sleep");

    chk_wake_write: assert property (
        (powered_down && wreg_done) |=> converting && !st_reg.continuous)
        else $error("register write wake not single conversion");

    chk_wake_start: assert property (
        (powered_down && start_cmd) |=> converting
            && st_reg.continuous == $past(conversion_mode_select))
        else $error("begin command wake mode wrong");

    chk_no_convert: assert property (
        (powered_down && !start_cmd && !wreg_done) |=> !complete && !converting)
        else $error("conversion while powered down");

    chk_shared_ready: assert property (
        (complete && ready_on_output_select && !cs_s)
            |=> !serial_out_ready_pin && !conv_done_n_pin)
        else $error("shared output did not fall with ready");

    chk_div_normal: assert property (
        (mod_tick && !turbo_select) |=> !mod_tick [*7] ##1 (!mod_tick || $past(turbo_select)))
        else $error("modulator tick too soon");

    chk_timeout_reset: assert property (
        timeout |=> st_reg.bit_cnt == 3'h0 && st_reg.timeout_cnt == 15'h0000)
        else $error("timeout did not reset serial port");

    cov_start_wake: cover property (powered_down && start_cmd);
    cov_sleep_pending: cover property (complete && st_reg.sleep_pending);
    cov_duty_entry: cover property (complete && st_next.state == DUTY_WAIT);
    cov_timeout: cover property (timeout);
endmodule // adc_serial_port

// File: core/adc_port_defines.svh
/*
 * constants of the converter serial port and mode sequencer: command codes,
 * divider ratios, timeout and pulse counts.
 * assumes it is included by bare name before use.
 */
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// command byte codes, upper seven bits (last bit is don't care)
`define ADC_CMD_START 7'h04
`define ADC_CMD_SLEEP 7'h01
// upper nibble codes
`define ADC_CMD_RDATA 4'h1
`define ADC_CMD_WREG 4'h4
// field positions of the register write count
`define ADC_WREG_NN_MSB 1
`define ADC_WREG_NN_LSB 0

// modulator clock divide ratios
`define ADC_MOD_DIV_NORMAL 16
`define ADC_MOD_DIV_TURBO 8

// serial timeout in modulator periods
`define ADC_TIMEOUT_NORMAL 13955
`define ADC_TIMEOUT_TURBO 27910

// ready pulse length before each new result, modulator periods
`define ADC_CONV_DONE_N_PIN_PULSE 2
// low-power periods after each conversion in duty-cycle operation
`define ADC_DUTY_IDLE_PERIODS 3

// reset values
`define ADC_RESULT_RESET 16'h0000

`endif

// File: core/adc_port_pkg.sv
/*
 * types of the converter serial port and mode sequencer.
 * assumes nothing of its surroundings.
 */
package adc_port_pkg;

    typedef enum logic [1:0] {
        LOW_POWER_IDLE,
        CONVERTING,
        DUTY_WAIT,
        POWERED_DOWN
    } power_state_t;

    typedef struct packed {
        power_state_t state;
        logic continuous;
        logic sleep_pending;
        logic [15:0] conv_cnt;
        logic sclk_prev;
        logic [2:0] bit_cnt;
        logic [7:0] in_shift;
        logic [2:0] wreg_left;
        logic [15:0] out_shift;
        logic out_active;
        logic sdo;
        logic oe;
        logic conv_done_n_pin_n;
        logic [15:0] result;
        logic [14:0] timeout_cnt;
    } port_state_t;

    typedef struct packed {
        logic [3:0] count;
        logic tick;
        logic mod_clk;
    } div_state_t;

endpackage

// File: core/pin_sync.sv
/*
 * two flip-flop synchroniser for a group of pin inputs.
 * assumes inputs are asynchronous to clock.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 3
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic [WIDTH-1:0] pins_async,
    input wire logic [WIDTH-1:0] reset_value,
    output logic [WIDTH-1:0] pins_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t sync_reg, sync_next;

    initial begin
        if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second
    always_comb begin
        sync_next = sync_reg;
        sync_next.stage1 = pins_async;
        sync_next.stage2 = sync_reg.stage1;
    end

    // reset loads the idle level of each pin, so no false edge follows it
    always_ff @(posedge clock) begin
        if (reset) begin
            sync_reg <= {reset_value, reset_value};
        end else if (clock_enable) begin
            sync_reg <= sync_next;
        end
    end

    assign pins_sync = sync_reg.stage2;
endmodule // pin_sync

// File: core/mod_clock_divider.sv
/*
 * modulator clock divider: one tick per modulator period and a square
 * modulator clock level.
 * assumes the system clock drives clock.
 */
`timescale 1ns/1ps
`include "adc_port_defines.svh"
module mod_clock_divider #(
    parameter int unsigned DIV_NORMAL = `ADC_MOD_DIV_NORMAL,
    parameter int unsigned DIV_TURBO = `ADC_MOD_DIV_TURBO
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic turbo_select,
    output logic mod_tick,
    output logic modulator_clock
);
    import adc_port_pkg::*;

    div_state_t div_reg, div_next;
    logic [3:0] last;

    initial begin
        if (DIV_NORMAL < 2 || DIV_NORMAL > 16 || DIV_TURBO < 2 || DIV_TURBO > 16)
            $error("mod_clock_divider: ratios must lie in 2..16");
    end

    // divide by 16 normally, by 8 in turbo
    always_comb begin
        last = turbo_select ? 4'(DIV_TURBO - 1) : 4'(DIV_NORMAL - 1);
        div_next = div_reg;
        div_next.tick = 1'b0;
        if (div_reg.count >= last) begin
            div_next.count = 4'h0;
            div_next.tick = 1'b1;
        end else begin
            div_next.count = div_reg.count + 4'h1;
        end
        div_next.mod_clk = (div_next.count < {1'b0, last[3:1]} + 4'h1);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            div_reg <= '0;
        end else if (clock_enable) begin
            div_reg <= div_next;
        end
    end

    assign mod_tick = div_reg.tick & clock_enable;
    assign modulator_clock = div_reg.mod_clk;
endmodule // mod_clock_divider

// File: testbench/host_model.sv
/*
 * host model: serial bus master that drives chip select, serial clock and
 * data in, mode 1, and samples the shared data output.
 * assumes the device samples its pins through synchronisers on clock.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    localparam int HALF = 6; // clocks per serial clock phase, above the sync minimum

    // idle levels at time zero: deselected, serial clock low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // chip select change, then a settling gap before any clock edge
    task automatic select(input logic level);
        @(posedge clock);
        cs_n <= level;
        repeat (4) @(posedge clock);
    endtask

    // shift nb bits msb first: data set on the rise, device samples on the fall
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            @(posedge clock);
            sclk <= 1'b1;
            din <= tx[i];
            repeat (HALF) @(posedge clock);
            rx[i] = dout_oe ? dout : 1'bx;
            sclk <= 1'b0;
            repeat (HALF - 1) @(posedge clock);
        end
        // data line inverted at the end leaves no stale level behind
        din <= ~din;
    endtask
endmodule // host_model

// File: testbench/testbench.sv
/*
 * self-checking bench of the converter serial port: commands, modes, ready.
 * assumes host_model and the core files are compiled before it.
 */
`timescale 1ns/1ps
module testbench;
    import adc_port_pkg::*;
    localparam int MODP = 16; // clocks per normal modulator period
    localparam int PER6 = 4; // rate 6 period, 256 over PERIOD_DIV 64
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cs_n, sclk, din, sout, soe, done_n, mclk, conv, pdown, aen, ren, ien, lsw;
    logic mode_sel = 1'b0;
    logic rdy_sel = 1'b0;
    logic duty_sel = 1'b0;
    logic turbo_sel = 1'b0;
    logic [2:0] rate = 3'h6;
    logic ce = 1'b1;
    logic [15:0] conv_val = 16'h8001;
    logic [15:0] r16;
    logic [7:0] r8;
    power_state_t pstate;
    int n_fail = 0;
    int compares = 0;
    int n;

    always #20 clock = ~clock;

    host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(sout),
        .dout_oe(soe));
    adc_serial_port #(.TIMEOUT_NORMAL(20), .TIMEOUT_TURBO(40), .PERIOD_DIV(64)) uut (
        .clock(clock), .reset(reset), .clock_enable(ce), .cs_n_pin(cs_n),
        .sclk_pin(sclk), .din_pin(din), .serial_out_ready_pin(sout),
        .serial_out_ready_pin_oe(soe), .conv_done_n_pin(done_n),
        .conversion_mode_select(mode_sel), .ready_on_output_select(rdy_sel),
        .duty_cycle_select(duty_sel), .turbo_select(turbo_sel), .rate_select(rate),
        .conv_result(conv_val), .modulator_clock(mclk), .converting(conv),
        .powered_down(pdown), .analog_enable(aen), .reference_enable(ren),
        .excitation_current_source_enable(ien), .low_side_switch_closed(lsw),
        .power_state(pstate));

    // compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic end_of_test;
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // waits and spans sampled on the falling clock edge, bounded except the mod_period edge searches
    task automatic wait_state(input power_state_t s);
        for (int k = 0; k < 400 && pstate !== s; k++) @(negedge clock);
    endtask
    task automatic span_state(input power_state_t s, output int c);
        for (c = 0; c < 1000 && pstate === s; c++) @(negedge clock);
    endtask
    task automatic wait_ready(input logic lvl);
        for (int k = 0; k < 400 && done_n !== lvl; k++) @(negedge clock);
    endtask
    task automatic mod_period(output int c);
        while (mclk === 1'b1) @(negedge clock);
        while (mclk !== 1'b1) @(negedge clock);
        for (c = 0; c < 64 && mclk === 1'b1; c++) @(negedge clock);
        for (; c < 64 && mclk === 1'b0; c++) @(negedge clock);
    endtask

    // one framed command byte
    task automatic cmd(input logic [7:0] b);
        host.select(1'b0);
        host.xfer(b, 8, r8);
        host.select(1'b1);
        @(negedge clock);
    endtask

    // one framed 16-bit result read, din held low
    task automatic read16(output logic [15:0] v);
        host.select(1'b0);
        host.xfer(8'h00, 8, v[15:8]);
        host.xfer(8'h00, 8, v[7:0]);
        host.select(1'b1);
        @(negedge clock);
    endtask

    // watchdog: the whole sequence needs well under 10000 clocks
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        // power-up conversion, ready low, result read out
        @(negedge clock);
        check("oe deselected", 16'h0, soe);
        wait_state(LOW_POWER_IDLE);
        check("power-up idle", LOW_POWER_IDLE, pstate);
        check("ready low", 16'h0, done_n);
        read16(r16);
        check("result", 16'h8001, r16);
        check("ready cleared", 16'h1, done_n);
        // modulator rates, normal then turbo
        mod_period(n);
        check("mod normal", MODP, n);
        @(posedge clock) turbo_sel <= 1'b1;
        mod_period(n);
        check("mod turbo", MODP / 2, n);
        @(posedge clock) turbo_sel <= 1'b0;
        // sleep, then nothing converts
        cmd(8'h03);
        check("sleep", POWERED_DOWN, pstate);
        check("analog off", 16'h0, {aen, ren, ien, lsw});
        check("down flags", 16'h1, {conv, pdown});
        repeat (200) @(negedge clock);
        check("no conversion", POWERED_DOWN, pstate);
        // begin wakes into a single conversion; a low clock enable freezes it
        @(posedge clock) conv_val <= 16'h7ffe;
        cmd(8'h09);
        check("begin wakes", CONVERTING, pstate);
        check("analog on", 16'hf, {aen, ren, ien, lsw});
        check("run flags", 16'h2, {conv, pdown});
        @(posedge clock) ce <= 1'b0;
        repeat (100) @(negedge clock);
        check("frozen", CONVERTING, pstate);
        @(posedge clock) ce <= 1'b1;
        wait_state(LOW_POWER_IDLE);
        check("single done", LOW_POWER_IDLE, pstate);
        read16(r16);
        check("new result", 16'h7ffe, r16);
        // register write in power-down: one conversion despite continuous select
        cmd(8'h02);
        @(posedge clock) mode_sel <= 1'b1;
        host.select(1'b0);
        host.xfer(8'h40, 8, r8);
        host.xfer(8'h00, 8, r8);
        host.select(1'b1);
        @(negedge clock);
        check("write wakes", CONVERTING, pstate);
        wait_state(LOW_POWER_IDLE);
        check("write single", LOW_POWER_IDLE, pstate);
        // continuous unread: ready pulses high for two modulator periods
        cmd(8'h08);
        wait_ready(1'b0);
        wait_ready(1'b1);
        for (n = 0; n < 200 && done_n === 1'b1; n++) @(negedge clock);
        check("ready pulse", 2 * MODP, n);
        check("continuous", CONVERTING, pstate);
        // shared output follows ready while selected
        @(posedge clock) rdy_sel <= 1'b1;
        host.select(1'b0);
        wait_ready(1'b1);
        check("shared high", 16'h1, sout);
        wait_ready(1'b0);
        check("shared falls", 16'h0, sout);
        host.select(1'b1);
        @(negedge clock);
        check("oe released", 16'h0, soe);
        @(posedge clock) rdy_sel <= 1'b0;
        // sleep during a long conversion waits for its end
        @(posedge clock) rate <= 3'h4;
        cmd(8'h08);
        cmd(8'h02);
        check("sleep pending", CONVERTING, pstate);
        wait_state(POWERED_DOWN);
        check("sleep after end", POWERED_DOWN, pstate);
        // duty-cycle: three idle conversion periods after each conversion
        @(posedge clock) rate <= 3'h6;
        @(posedge clock) duty_sel <= 1'b1;
        cmd(8'h08);
        wait_state(DUTY_WAIT);
        span_state(DUTY_WAIT, n);
        check("duty wait", 3 * PER6 * MODP, n);
        check("duty repeat", CONVERTING, pstate);
        @(posedge clock) duty_sel <= 1'b0;
        @(posedge clock) mode_sel <= 1'b0;
        cmd(8'h08);
        wait_state(LOW_POWER_IDLE);
        check("single again", LOW_POWER_IDLE, pstate);
        // broken command dropped by timeout, next byte decodes alone
        host.select(1'b0);
        host.xfer(8'h00, 4, r8);
        repeat (22 * MODP) @(posedge clock);
        host.xfer(8'h03, 8, r8);
        host.select(1'b1);
        @(negedge clock);
        check("timeout", POWERED_DOWN, pstate);
        end_of_test();
    end
endmodule // testbench
